/* File: hw/dtc_top.sv */
// Overview of operation
// - Two units, each high and low byte
// - Timer ticks at clock/12 or clock/4
// - Pin sampled at C4, high-low counts
// - Registers update at C3, next cycle
// - Function select bits 2 and 6
// - Two-bit mode field per unit
// - Time base bits reset to divide-by-12
// - Mode 0: 13 bits, low top ignored
// - High increments when prescaler bit falls
// - Wrap 1FFFh to 0 sets overflow flag
// - Advance when run and gate allow
// - Unit 0 and unit 1 count pins
// - Flag cleared on interrupt vectoring
// - Software may set or clear flags
// - Machine cycle is four clocks
module dtc_top
    import dtc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [3:0] reg_addr,       // Register index
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,         // Write strobe
    input  wire logic       reg_rd,         // Read strobe
    input  wire logic       unit0_count_pin,
    input  wire logic       unit1_count_pin,
    input  wire logic [1:0] gate_pin,       // Per unit gate pins
    input  wire logic [1:0] vector_ack,     // Processor vectors to unit n
    output logic      [7:0] reg_rdata,
    output logic      [1:0] overflow_flag,  // Flags to the interrupt controller
    output logic            irq
);
    localparam int NUNITS = 2;

    logic [7:0] timer_mode_register_r;     // Mode, function, gate per unit
    logic [7:0] timer_control_register_r;  // Run bits and overflow flags
    logic [7:0] clock_control_register_r;  // Time base bits
    logic [1:0] irq_stat_r;                // Sticky overflow events
    logic [1:0] irq_en_r;
    logic [7:0] rdata_nxt;
    logic [1:0] irq_stat_nxt;

    // Machine cycle phase counter, C1..C4
    logic [1:0] phase_r;
    logic       upd_en;                    // C3 pulse
    logic       smp_en;                    // C4 pulse
    logic [1:0] tb_div_r;                  // Machine cycles per standard tick
    logic       std_tick;

    logic [7:0] low_q   [NUNITS];
    logic [7:0] high_q  [NUNITS];
    logic [NUNITS-1:0] ovf_ev;
    logic [NUNITS-1:0] pins;

    // Four clocks per machine cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_r <= 2'd0;
        end else begin
            phase_r <= phase_r + 2'd1;
        end
    end
    assign upd_en = (phase_r == DTC_PH_C3);
    assign smp_en = (phase_r == DTC_PH_C4);

    // Divide machine cycles by three for the clock/12 rate
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tb_div_r <= 2'd0;
        end else if (upd_en) begin
            tb_div_r <= (tb_div_r == DTC_TB_STD_CYC - 2'd1) ? 2'd0 : tb_div_r + 2'd1;
        end
    end
    assign std_tick = (tb_div_r == DTC_TB_STD_CYC - 2'd1);

    // Count pins per unit
    assign pins = {unit1_count_pin, unit0_count_pin};

    // Both units from one loop
    generate
        for (genvar u = 0; u < NUNITS; u++) begin : g_unit
            localparam int MB = u * DTC_MODE_UNIT_STRIDE;
            logic tick;
            // Turbo bit picks every machine cycle, else every third
            assign tick = clock_control_register_r[DTC_CLK_TB_BIT0 + u]
                        ? (DTC_TB_TURBO_CYC == 2'd1) : std_tick;
            dtc_unit u_unit (
                .sys_clk     (sys_clk),
                .reset       (reset),
                .upd_en      (upd_en),
                .smp_en      (smp_en),
                .tick_en     (tick),
                .func_cnt    (timer_mode_register_r[MB + DTC_MODE_FUNC_BIT]),
                .gate_ctl    (timer_mode_register_r[MB + DTC_MODE_GATE_BIT]),
                .run         (timer_control_register_r[DTC_CTRL_RUN_BIT0 + 2*u]),
                .mode        ({timer_mode_register_r[MB + DTC_MODE_M1_BIT],
                               timer_mode_register_r[MB + DTC_MODE_M0_BIT]}),
                .count_pin   (pins[u]),
                .gate_pin    (gate_pin[u]),
                .wr_low      (reg_wr && reg_addr == DTC_ADDR_LOW0 + 4'(2*u)),
                .wr_high     (reg_wr && reg_addr == DTC_ADDR_HIGH0 + 4'(2*u)),
                .wdata       (reg_wdata),
                .low_r       (low_q[u]),
                .high_r      (high_q[u]),
                .ovf_pulse_r (ovf_ev[u])
            );
        end
    endgenerate

    // Mode and clock control registers written by software
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer_mode_register_r    <= DTC_RST_BYTE;
            clock_control_register_r <= DTC_RST_CLKCTL;  // Time base bits start at 0
        end else if (reg_wr) begin
            if (reg_addr == DTC_ADDR_MODE) begin
                timer_mode_register_r <= reg_wdata;
            end
            if (reg_addr == DTC_ADDR_CLKCTL) begin
                clock_control_register_r <= reg_wdata;
            end
        end
    end

    // Control register: hardware set wins over software write and vector clear
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            timer_control_register_r <= DTC_RST_BYTE;
        end else begin
            for (int u = 0; u < NUNITS; u++) begin
                if (ovf_ev[u]) begin
                    timer_control_register_r[DTC_CTRL_OVF_BIT0 + 2*u] <= 1'b1;
                end else if (reg_wr && reg_addr == DTC_ADDR_CTRL) begin
                    timer_control_register_r[DTC_CTRL_OVF_BIT0 + 2*u]
                        <= reg_wdata[DTC_CTRL_OVF_BIT0 + 2*u];
                end else if (vector_ack[u]) begin
                    timer_control_register_r[DTC_CTRL_OVF_BIT0 + 2*u] <= 1'b0;
                end
                if (reg_wr && reg_addr == DTC_ADDR_CTRL) begin
                    timer_control_register_r[DTC_CTRL_RUN_BIT0 + 2*u]
                        <= reg_wdata[DTC_CTRL_RUN_BIT0 + 2*u];
                end
            end
            if (reg_wr && reg_addr == DTC_ADDR_CTRL) begin
                // Bits outside run and flag fields are plain storage
                timer_control_register_r[3:0] <= reg_wdata[3:0];
            end
        end
    end

    // Sticky status: set beats write-one-to-clear
    assign irq_stat_nxt = ovf_ev
        | (irq_stat_r & ~((reg_wr && reg_addr == DTC_ADDR_IRQ_CLR) ? reg_wdata[1:0] : 2'b00));
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq_stat_r <= 2'b00;
            irq_en_r   <= 2'b00;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            if (reg_wr && reg_addr == DTC_ADDR_IRQ_EN) begin
                irq_en_r <= reg_wdata[1:0];
            end
        end
    end

    // Interrupt and flag outputs registered
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            irq           <= 1'b0;
            overflow_flag <= 2'b00;
        end else begin
            irq <= |(irq_stat_nxt & irq_en_r);
            overflow_flag <= {timer_control_register_r[DTC_CTRL_OVF_BIT0 + 2],
                              timer_control_register_r[DTC_CTRL_OVF_BIT0]};
        end
    end

    // Read mux; unmapped and write-only indices read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            DTC_ADDR_MODE:     rdata_nxt = timer_mode_register_r;
            DTC_ADDR_CTRL:     rdata_nxt = timer_control_register_r;
            DTC_ADDR_CLKCTL:   rdata_nxt = clock_control_register_r;
            DTC_ADDR_LOW0:     rdata_nxt = low_q[0];
            DTC_ADDR_HIGH0:    rdata_nxt = high_q[0];
            DTC_ADDR_LOW1:     rdata_nxt = low_q[1];
            DTC_ADDR_HIGH1:    rdata_nxt = high_q[1];
            DTC_ADDR_IRQ_STAT: rdata_nxt = {6'h00, irq_stat_r};
            DTC_ADDR_IRQ_EN:   rdata_nxt = {6'h00, irq_en_r};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
        end
    end

    // Checks
    property p_ovf_flag;
        @(posedge sys_clk) disable iff (reset)
        ovf_ev[0] |=> timer_control_register_r[DTC_CTRL_OVF_BIT0];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

    property p_vec_clr;
        @(posedge sys_clk) disable iff (reset)
        vector_ack[0] && !ovf_ev[0] && !reg_wr |=> !timer_control_register_r[DTC_CTRL_OVF_BIT0];
    endproperty
    a_vec_clr: assert property (p_vec_clr) else $error("flag kept after vector");

    property p_sw_write;
        @(posedge sys_clk) disable iff (reset)
        reg_wr && reg_addr == DTC_ADDR_CTRL && !ovf_ev[0]
        |=> timer_control_register_r[DTC_CTRL_OVF_BIT0] == $past(reg_wdata[DTC_CTRL_OVF_BIT0]);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("flag write lost");

    sequence s_c3;
        phase_r == DTC_PH_C3;
    endsequence
    property p_cycle;
        @(posedge sys_clk) disable iff (reset)
        s_c3 |-> ##4 s_c3;
    endproperty
    a_cycle: assert property (p_cycle) else $error("machine cycle not four clocks");

    property p_c3_only;
        @(posedge sys_clk) disable iff (reset)
        !upd_en |=> $stable(low_q[1]) || $past(reg_wr);
    endproperty
    a_c3_only: assert property (p_c3_only) else $error("count moved off C3");

    property p_std_rate;
        @(posedge sys_clk) disable iff (reset)
        std_tick && upd_en |-> ##12 (std_tick && upd_en);
    endproperty
    a_std_rate: assert property (p_std_rate) else $error("standard tick not 12 clocks");

    property p_irq;
        @(posedge sys_clk) disable iff (reset)
        |(irq_stat_r & irq_en_r) |-> irq || $past(!(|(irq_stat_r & irq_en_r)));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_prescale;
        @(posedge sys_clk) disable iff (reset)
        $changed(high_q[0]) && !$past(reg_wr) |-> low_q[0][DTC_M0_LOW_BITS-1:0] == 5'h00;
    endproperty
    a_prescale: assert property (p_prescale) else $error("high moved without carry");
endmodule

/* File: hw/dtc_pkg.sv */
package dtc_pkg;
    // Register indices on the plain register port
    localparam logic [3:0] DTC_ADDR_MODE     = 4'h0;  // timer_mode_register
    localparam logic [3:0] DTC_ADDR_CTRL     = 4'h1;  // timer_control_register
    localparam logic [3:0] DTC_ADDR_CLKCTL   = 4'h2;  // clock_control_register
    localparam logic [3:0] DTC_ADDR_LOW0     = 4'h3;  // Unit 0 count_low_byte
    localparam logic [3:0] DTC_ADDR_HIGH0    = 4'h4;  // Unit 0 count_high_byte
    localparam logic [3:0] DTC_ADDR_LOW1     = 4'h5;  // Unit 1 count_low_byte
    localparam logic [3:0] DTC_ADDR_HIGH1    = 4'h6;  // Unit 1 count_high_byte
    localparam logic [3:0] DTC_ADDR_IRQ_STAT = 4'h7;  // Sticky event status (read only)
    localparam logic [3:0] DTC_ADDR_IRQ_CLR  = 4'h8;  // Write one to clear (write only)
    localparam logic [3:0] DTC_ADDR_IRQ_EN   = 4'h9;  // Event enable

    // Field positions inside the mode register, unit n at offset 4*n
    localparam int DTC_MODE_UNIT_STRIDE = 4;
    localparam int DTC_MODE_M0_BIT      = 0;  // mode_field_low
    localparam int DTC_MODE_M1_BIT      = 1;  // mode_field_high
    localparam int DTC_MODE_FUNC_BIT    = 2;  // Function select: 0 timer, 1 counter
    localparam int DTC_MODE_GATE_BIT    = 3;  // Gate control
    // Control register: run bit at 4+2n, overflow flag at 5+2n
    localparam int DTC_CTRL_RUN_BIT0    = 4;
    localparam int DTC_CTRL_OVF_BIT0    = 5;
    // Clock control: time base bit at 3+n
    localparam int DTC_CLK_TB_BIT0      = 3;

    // Reset values
    localparam logic [7:0] DTC_RST_BYTE   = 8'h00;
    localparam logic [7:0] DTC_RST_CLKCTL = 8'h01;

    // Machine cycle: four clock periods, phases C1..C4 as a two-bit count 0..3
    localparam int         DTC_MC_CLOCKS    = 4;
    localparam logic [1:0] DTC_PH_C3        = 2'd2;
    localparam logic [1:0] DTC_PH_C4        = 2'd3;
    // Time base dividers in machine cycles: 12 clocks = 3 cycles, 4 clocks = 1
    localparam logic [1:0] DTC_TB_STD_CYC   = 2'd3;
    localparam logic [1:0] DTC_TB_TURBO_CYC = 2'd1;
    // Mode 0 geometry
    localparam int         DTC_M0_LOW_BITS  = 5;
    localparam logic [1:0] DTC_MODE0        = 2'b00;
endpackage

/* File: hw/dtc_unit.sv */
// One timer/counter unit in mode 0; steps on the shared C3 enable
module dtc_unit
    import dtc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       upd_en,      // C3 pulse
    input  wire logic       smp_en,      // C4 pulse
    input  wire logic       tick_en,     // Time base tick for this unit
    input  wire logic       func_cnt,    // 1: count pin edges
    input  wire logic       gate_ctl,
    input  wire logic       run,
    input  wire logic [1:0] mode,
    input  wire logic       count_pin,
    input  wire logic       gate_pin,
    input  wire logic       wr_low,
    input  wire logic       wr_high,
    input  wire logic [7:0] wdata,
    output logic      [7:0] low_r,
    output logic      [7:0] high_r,
    output logic            ovf_pulse_r
);
    logic smp_cur_r;       // Pin sample at the latest C4
    logic edge_pend_r;     // Edge seen, to be counted at next C3
    logic enabled;
    logic step;
    logic [4:0] low_nxt;

    // Sample the count pin once per machine cycle
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            smp_cur_r <= 1'b0;
        end else if (smp_en) begin
            smp_cur_r <= count_pin;
        end
    end

    // High then low sample is an edge; held until the following C3
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            edge_pend_r <= 1'b0;
        end else if (smp_en) begin
            edge_pend_r <= smp_cur_r & ~count_pin;
        end else if (upd_en) begin
            edge_pend_r <= 1'b0;
        end
    end

    // Run and gate qualify counting
    assign enabled = run & (~gate_ctl | gate_pin);
    assign step = upd_en & enabled & (mode == DTC_MODE0)
                & (func_cnt ? edge_pend_r : tick_en);
    assign low_nxt = low_r[DTC_M0_LOW_BITS-1:0] + 5'd1;

    // Count registers; 5-bit prescaler into the 8-bit high byte
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            low_r  <= DTC_RST_BYTE;
            high_r <= DTC_RST_BYTE;
        end else begin
            if (wr_low) begin
                low_r <= wdata;
            end else if (step) begin
                low_r[DTC_M0_LOW_BITS-1:0] <= low_nxt;
            end
            if (wr_high) begin
                high_r <= wdata;
            end else if (step && low_r[DTC_M0_LOW_BITS-1:0] == 5'h1f) begin
                high_r <= high_r + 8'd1;
            end
        end
    end

    // Overflow when 1FFFh rolls to 0000h
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ovf_pulse_r <= 1'b0;
        end else begin
            ovf_pulse_r <= step && !wr_low && !wr_high && high_r == 8'hff
                         && low_r[DTC_M0_LOW_BITS-1:0] == 5'h1f;
        end
    end

    // Counting is confined to pin edges when the counter function is chosen
    property p_pin_step;
        @(posedge sys_clk) disable iff (reset)
        (func_cnt && mode == DTC_MODE0 && step) |-> edge_pend_r;
    endproperty
    a_pin_step: assert property (p_pin_step) else $error("pin count without edge");

    property p_gate;
        @(posedge sys_clk) disable iff (reset)
        (!run || (gate_ctl && !gate_pin)) && !wr_low |=> $stable(low_r);
    endproperty
    a_gate: assert property (p_gate) else $error("counted while stopped");
endmodule

/* File: tb/dtc_pins_model.sv */
// Drives the count and gate pins the way an external source would
module dtc_pins_model (
    input  wire logic       sys_clk,
    output logic      [1:0] count_pin,  // Count pins, idle high
    output logic      [1:0] gate_pin    // Gate pins, start low
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins idle high so the first sample never looks like an edge
    initial begin
        count_pin = 2'b11;
        gate_pin  = 2'b00;
    end

    // Each level is held for 12 clocks, three machine cycles
    // Slower than needed: three samples per level leave margin at C4
    task automatic pulses(input int u, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (12) @(posedge sys_clk);
            count_pin[u] <= 1'b0;
            repeat (12) @(posedge sys_clk);
            count_pin[u] <= 1'b1;
        end
        // Let the last edge land in the count register
        repeat (12) @(posedge sys_clk);
    endtask

    // Gate level for one unit, changed just after an edge
    task automatic set_gate(input int u, input logic v);
        @(posedge sys_clk);
        gate_pin[u] <= v;
    endtask
endmodule

/* File: tb/dual_timer_counter_mode0_tb.sv */
module dual_timer_counter_mode0_tb;
    import dtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic       sys_clk;     // 100 MHz clock
    logic       reset;       // Active high reset
    logic [3:0] reg_addr;    // Register index
    logic [7:0] reg_wdata;   // Write data
    logic       reg_wr;      // Write strobe
    logic       reg_rd;      // Read strobe
    logic [7:0] reg_rdata;   // Read data, one cycle after strobe
    logic [1:0] cnt_pin;     // Count pins from the model
    logic [1:0] gate_pin;    // Gate pins from the model
    logic [1:0] vector_ack;  // Vectoring pulses
    logic [1:0] ovf_flag;    // Overflow flags
    logic       irq;         // Interrupt level
    int         n_fail;      // Mismatches
    int         n_checks;    // Comparisons

    dtc_top dtc_top_inst (
        .sys_clk         (sys_clk),
        .reset           (reset),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .unit0_count_pin (cnt_pin[0]),
        .unit1_count_pin (cnt_pin[1]),
        .gate_pin        (gate_pin),
        .vector_ack      (vector_ack),
        .reg_rdata       (reg_rdata),
        .overflow_flag   (ovf_flag),
        .irq             (irq)
    );

    dtc_pins_model dtc_pins_model_inst (
        .sys_clk   (sys_clk),
        .count_pin (cnt_pin),
        .gate_pin  (gate_pin)
    );

    // Free running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Compare with a tolerance; tolerance covers machine-cycle phase
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input int tol);
        logic ok;
        n_checks++;
        if (tol == 0) begin
            ok = (got === exp);
        end else begin
            ok = (^got !== 1'bx) && (got + tol >= exp) && (got <= exp + tol);
        end
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe; data taken in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Thirteen-bit mode 0 count of one unit
    task automatic rdcnt(input int u, output logic [15:0] c);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(DTC_ADDR_LOW0 + 4'(2 * u), lo);
        rd(DTC_ADDR_HIGH0 + 4'(2 * u), hi);
        c = {3'b000, hi, lo[4:0]};
    endtask

    // Reset values, write-only and unmapped reads
    task automatic t_reset();
        logic [7:0] d;
        for (int a = 0; a < 10; a++) begin
            rd(4'(a), d);
            chk(16'(d), (a == 2) ? 16'h0001 : 16'h0000, 0);
        end
        rd(4'hF, d);
        chk(16'(d), 16'h0000, 0);
    endtask

    // Unit 0 turbo, unit 1 standard; other modes hold the count
    task automatic t_rate();
        logic [15:0] c;
        wr(DTC_ADDR_CLKCTL, 8'h09);
        wr(DTC_ADDR_MODE, 8'h00);
        for (int u = 0; u < 2; u++) begin
            wr(DTC_ADDR_LOW0 + 4'(2 * u), 8'h00);
            wr(DTC_ADDR_HIGH0 + 4'(2 * u), 8'h00);
        end
        wr(DTC_ADDR_CTRL, 8'h50);
        repeat (240) @(posedge sys_clk);
        wr(DTC_ADDR_CTRL, 8'h00);
        rdcnt(0, c);
        chk(c, 16'd60, 1);
        rdcnt(1, c);
        chk(c, 16'd20, 1);
        for (int m = 1; m < 4; m++) begin
            wr(DTC_ADDR_MODE, 8'(m));
            wr(DTC_ADDR_CTRL, 8'h10);
            repeat (40) @(posedge sys_clk);
            wr(DTC_ADDR_CTRL, 8'h00);
            rdcnt(0, c);
            chk(c, 16'd60, 1);
        end
    endtask

    // Edge counting per unit, with the gate held low then high
    task automatic t_count(input int u);
        logic [15:0] c;
        wr(DTC_ADDR_MODE, (u == 1) ? 8'hC0 : 8'h0C);
        wr(DTC_ADDR_LOW0 + 4'(2 * u), 8'h00);
        wr(DTC_ADDR_HIGH0 + 4'(2 * u), 8'h00);
        wr(DTC_ADDR_CTRL, (u == 1) ? 8'h40 : 8'h10);
        dtc_pins_model_inst.pulses(u, 2);
        rdcnt(u, c);
        chk(c, 16'd0, 0);
        dtc_pins_model_inst.set_gate(u, 1'b1);
        dtc_pins_model_inst.pulses(u, 3);
        rdcnt(u, c);
        chk(c, 16'd3, 0);
        dtc_pins_model_inst.set_gate(u, 1'b0);
        wr(DTC_ADDR_CTRL, 8'h00);
    endtask

    // Wrap, status, mask, clear, vector clear and software flags
    task automatic t_wrap();
        logic [15:0] c;
        logic [7:0]  d;
        int          i;
        wr(DTC_ADDR_IRQ_EN, 8'h00);
        wr(DTC_ADDR_MODE, 8'h00);
        wr(DTC_ADDR_LOW0, 8'hFF);
        wr(DTC_ADDR_HIGH0, 8'hFF);
        wr(DTC_ADDR_CTRL, 8'h10);
        for (i = 0; i < 40 && ovf_flag[0] !== 1'b1; i++) @(posedge sys_clk);
        chk(16'(ovf_flag), 16'h0001, 0);
        wr(DTC_ADDR_CTRL, 8'h20);
        rdcnt(0, c);
        chk(c, 16'd0, 1);
        chk(16'(irq), 16'h0000, 0);
        rd(DTC_ADDR_IRQ_STAT, d);
        chk(16'(d), 16'h0001, 0);
        wr(DTC_ADDR_IRQ_EN, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'(irq), 16'h0001, 0);
        wr(DTC_ADDR_IRQ_CLR, 8'h01);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'(irq), 16'h0000, 0);
        @(posedge sys_clk);
        vector_ack <= 2'b01;
        @(posedge sys_clk);
        vector_ack <= 2'b00;
        repeat (3) @(posedge sys_clk);
        #1 chk(16'(ovf_flag), 16'h0000, 0);
        wr(DTC_ADDR_CTRL, 8'hA0);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'(ovf_flag), 16'h0003, 0);
        wr(DTC_ADDR_CTRL, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk(16'(ovf_flag), 16'h0000, 0);
    endtask

    // Sole exit point of the run
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Cuts a hang short well after the expected run length
    initial begin
        #400000;
        n_fail++;
        complete_run();
    end

    // Main sequence
    initial begin
        n_fail     = 0;
        n_checks   = 0;
        reset      = 1'b1;
        reg_addr   = 4'h0;
        reg_wdata  = 8'h00;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        vector_ack = 2'b00;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_rate();
        t_count(0);
        t_count(1);
        t_wrap();
        complete_run();
    end
endmodule
